// ### inc/drt_pkg.sv
// shared types and constants for the dual reload timer
// assumes one 25 MHz system clock and a synchronous active-low reset
package drt_pkg;

   // system clock
   localparam int unsigned CLK_FREQ_HZ = 25000000;

   // prescaler division codes
   localparam logic [1:0] DIV_BY_1 = 2'h0;
   localparam logic [1:0] DIV_BY_4 = 2'h1;
   localparam logic [1:0] DIV_BY_32 = 2'h2;
   localparam logic [1:0] DIV_BY_256 = 2'h3;
   localparam logic [7:0] PRE_MASK_4 = 8'h03;
   localparam logic [7:0] PRE_MASK_32 = 8'h1F;
   localparam logic [7:0] PRE_MASK_256 = 8'hFF;
   localparam logic [7:0] PRE_RESET = 8'h00;

   // counter values
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [7:0] COUNT_ONE = 8'h01;
   localparam logic [7:0] COUNT_BORROW = 8'hFF;

   // noise rejector: falling edges of the 2,048 Hz reference needed
   localparam int unsigned REF_FREQ_HZ = 2048;
   localparam logic [1:0] REJECT_FALLS = 2'h2;

   // per-timer clock settings
   typedef struct packed {
      logic sourceSelect;   // 0 slow oscillator, 1 fast oscillator
      logic [1:0] divider;  // {divider_bit_hi, divider_bit_lo}
      logic runBit;
   } drt_timer_cfg_t;

   // shared mode settings
   typedef struct packed {
      logic widthModeBit;
      logic counterModeBit;
      logic filterSelectBit;
      logic edgePolarityBit;
      logic waveChannelSelect;
      logic waveOutputEnable;
   } drt_mode_cfg_t;

   // readable count values
   typedef struct packed {
      logic [7:0] t0Count;
      logic [7:0] t1Count;
      logic [7:0] heldHigh;
   } drt_count_read_t;

   // noise rejector states
   typedef enum logic [1:0] {
      FLT_STABLE = 2'b01,
      FLT_SEEN = 2'b10
   } drt_filter_state_t;

endpackage

// ### core/drt_prescaler.sv
// one prescaler: divides enable pulses of its source clock by 1, 4, 32 or 256
// assumes srcTick is a one-cycle pulse on clk, one per source clock period
`timescale 1ns/100ps
module drt_prescaler (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic srcTick,
   input wire logic runBit,
   input wire logic [1:0] divider,
   output logic outTick
);
   import drt_pkg::*;

   logic [7:0] phase_reg;

   function automatic logic [7:0] div_mask(input logic [1:0] code);
      unique case (code)
         DIV_BY_1: div_mask = PRE_RESET;
         DIV_BY_4: div_mask = PRE_MASK_4;
         DIV_BY_32: div_mask = PRE_MASK_32;
         DIV_BY_256: div_mask = PRE_MASK_256;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // stopped prescaler is cleared so each run starts from a whole period
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_reg <= PRE_RESET;
      end else if (!runBit) begin
         phase_reg <= PRE_RESET;
      end else if (srcTick) begin
         phase_reg <= phase_reg + COUNT_ONE;
      end
   end

   assign outTick = runBit && srcTick &&
                    ((phase_reg & div_mask(divider)) == div_mask(divider));

endmodule

// ### core/drt_timer.sv
// dual 8-bit reload down counter, cascadable to 16 bits, with square-wave
// and serial clock outputs
// assumes oscillator, reference and event pins are slow against clk (each
// level lasts at least two clk periods); control inputs are on clk
`timescale 1ns/100ps

// Notes on behaviour
// - each prescaler source picks slow oscillator on 0, fast oscillator on 1
// - division field 11 /256, 10 /32, 01 /4, 00 undivided
// - run bit 1 starts prescaler; counter decrements per prescaler output
// - in event mode timer 0 divider and source select are ignored
// - underflow sets its flag whatever the mask; mask only gates requests
// - square wave toggles on each selected underflow, half the underflow rate
// - in separate mode channel select 0 uses timer 0 underflows, 1 uses timer 1
// - wave enable 1 puts wave on squareWaveOut, 0 holds squareWaveOut high
// - enable gates the wave directly, so a short pulse may appear
// - separate mode serial clock is timer 1 underflows halved, needs only run
// - width mode 1 makes one 16-bit counter, timer 0 low byte
// - preset bit loads the counter from its reload value
// - in 16-bit mode timer 0 run bit starts and stops both bytes
// - stopping only halts the count clock; value is kept and resumed
// - low byte read latches high byte; software reads low byte first
// - underflow reloads and drives flag and square wave; timer 1 underflow also the serial clock
// - counter mode 0 timer mode (reset default), 1 counts event pin edges
// - edge polarity 0 counts falling edges, 1 rising edges
// - filter select 1 enables noise rejector on event input
// - rejector accepts change at second reference falling edge; source holds levels
// - writing 1 clears an interrupt flag; writing 0 leaves it
// - separate mode timer 1 only counts in timer mode
// - 16-bit underflow sets timer 1 interrupt flag
module drt_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slowOscillator,
   input wire logic fastOscillator,
   input wire logic refClock2048,
   input wire logic eventInputPin,
   input wire drt_pkg::drt_mode_cfg_t modeCfg,
   input wire drt_pkg::drt_timer_cfg_t t0Cfg,
   input wire drt_pkg::drt_timer_cfg_t t1Cfg,
   input wire logic t0PresetBit,
   input wire logic t1PresetBit,
   input wire logic [7:0] t0ReloadValue,
   input wire logic [7:0] t1ReloadValue,
   input wire logic t0IrqMask,
   input wire logic t1IrqMask,
   input wire logic t0IrqClear,
   input wire logic t1IrqClear,
   input wire logic lowReadStrobe,
   input wire logic wavePortPin,
   input wire logic wavePortHizCtrl,
   output logic t0IrqFlag,
   output logic t1IrqFlag,
   output logic t0IrqReq,
   output logic t1IrqReq,
   output logic t0Underflow,
   output logic t1Underflow,
   output drt_pkg::drt_count_read_t countReadBuffer,
   output logic squareWaveOut,
   output logic wavePinOut,
   output logic wavePinOe,
   output logic serialClock
);
   import drt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   // bit 0 slow osc, 1 fast osc, 2 reference, 3 event input
   logic [3:0] pinMeta_reg;
   logic [3:0] pinSync_reg;
   logic [3:0] pinPrev_reg;
   logic slowRise;
   logic fastRise;
   logic refFall;
   logic eventLevel;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinMeta_reg <= 4'h0;
         pinSync_reg <= 4'h0;
         pinPrev_reg <= 4'h0;
      end else begin
         pinMeta_reg <= {eventInputPin, refClock2048, fastOscillator, slowOscillator};
         pinSync_reg <= pinMeta_reg;
         pinPrev_reg <= pinSync_reg;
      end
   end

   assign slowRise = pinSync_reg[0] && !pinPrev_reg[0];
   assign fastRise = pinSync_reg[1] && !pinPrev_reg[1];
   assign refFall = !pinSync_reg[2] && pinPrev_reg[2];
   assign eventLevel = pinSync_reg[3];

   ////////////////////////////////////////////////////////////////////////////
   // prescalers, one per timer
   drt_timer_cfg_t tCfg [2];
   logic [1:0] srcTick;
   logic [1:0] preTick;
   logic [1:0] runEff;

   assign tCfg[0] = t0Cfg;
   assign tCfg[1] = t1Cfg;

   assign runEff[0] = t0Cfg.runBit;
   assign runEff[1] = modeCfg.widthModeBit ? t0Cfg.runBit : t1Cfg.runBit;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pre
         assign srcTick[gi] = tCfg[gi].sourceSelect ? fastRise : slowRise;
         drt_prescaler i_drt_prescaler (
            .clk(clk),
            .rst_n(rst_n),
            .srcTick(srcTick[gi]),
            .runBit(runEff[gi]),
            .divider(tCfg[gi].divider),
            .outTick(preTick[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // noise rejector and event edge detect
   // the rejector also needs the event level to stay different on every clock from the first fall to the second
   drt_filter_state_t fltState_reg;
   logic filtLevel_reg;
   logic eventPrev_reg;
   logic eventSel;
   logic eventEdge;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fltState_reg <= FLT_STABLE;
         filtLevel_reg <= 1'b0;
      end else if (eventLevel == filtLevel_reg) begin
         fltState_reg <= FLT_STABLE;
      end else if (refFall) begin
         unique case (fltState_reg)
            FLT_STABLE: fltState_reg <= FLT_SEEN;
            FLT_SEEN: begin
               filtLevel_reg <= eventLevel;
               fltState_reg <= FLT_STABLE;
            end
            default: fltState_reg <= FLT_STABLE;
         endcase
      end
   end

   assign eventSel = modeCfg.filterSelectBit ? filtLevel_reg : eventLevel;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eventPrev_reg <= 1'b0;
      end else begin
         eventPrev_reg <= eventSel;
      end
   end

   assign eventEdge = modeCfg.edgePolarityBit ? (eventSel && !eventPrev_reg) :
                      (!eventSel && eventPrev_reg);

   ////////////////////////////////////////////////////////////////////////////
   // count enables
   logic [7:0] count0_reg;
   logic [7:0] count1_reg;
   logic wide;
   logic tick0;
   logic cnt0En;
   logic cnt1En;
   logic zero0;
   logic zero1;

   assign wide = modeCfg.widthModeBit;
   assign zero0 = (count0_reg == COUNT_ZERO);
   assign zero1 = (count1_reg == COUNT_ZERO);

   assign tick0 = modeCfg.counterModeBit ? eventEdge : preTick[0];
   assign cnt0En = tick0 && t0Cfg.runBit;
   // a low-byte preset wins, so the high byte must not borrow or reload then
   assign cnt1En = wide ? (cnt0En && zero0 && !t0PresetBit) : (preTick[1] && t1Cfg.runBit);

   ////////////////////////////////////////////////////////////////////////////
   // down counters; preset has priority over a count in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count0_reg <= COUNT_RESET;
      end else if (t0PresetBit) begin
         count0_reg <= t0ReloadValue;
      end else if (cnt0En) begin
         if (zero0) begin
            count0_reg <= (wide && !zero1) ? COUNT_BORROW : t0ReloadValue;
         end else begin
            count0_reg <= count0_reg - COUNT_ONE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count1_reg <= COUNT_RESET;
      end else if (t1PresetBit) begin
         count1_reg <= t1ReloadValue;
      end else if (cnt1En) begin
         if (zero1) begin
            count1_reg <= t1ReloadValue;
         end else begin
            count1_reg <= count1_reg - COUNT_ONE;
         end
      end
   end

   assign t0Underflow = !wide && cnt0En && zero0 && !t0PresetBit;
   assign t1Underflow = cnt1En && zero1 && !t1PresetBit;

   ////////////////////////////////////////////////////////////////////////////
   // read hold of the high byte
   logic [7:0] heldHigh_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         heldHigh_reg <= COUNT_RESET;
      end else if (lowReadStrobe) begin
         heldHigh_reg <= count1_reg;
      end
   end

   assign countReadBuffer.t0Count = count0_reg;
   assign countReadBuffer.t1Count = count1_reg;
   assign countReadBuffer.heldHigh = heldHigh_reg;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt flags; an underflow wins over a clear in the same cycle
   logic t0Flag_reg;
   logic t1Flag_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         t0Flag_reg <= 1'b0;
      end else if (t0Underflow) begin
         t0Flag_reg <= 1'b1;
      end else if (t0IrqClear) begin
         t0Flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         t1Flag_reg <= 1'b0;
      end else if (t1Underflow) begin
         t1Flag_reg <= 1'b1;
      end else if (t1IrqClear) begin
         t1Flag_reg <= 1'b0;
      end
   end

   assign t0IrqFlag = t0Flag_reg;
   assign t1IrqFlag = t1Flag_reg;
   assign t0IrqReq = t0Flag_reg && t0IrqMask;
   assign t1IrqReq = t1Flag_reg && t1IrqMask;

   ////////////////////////////////////////////////////////////////////////////
   // square wave and serial clock
   logic waveUnderflow;
   logic wave_reg;
   logic serial_reg;

   // 16-bit mode has only the combined underflow, so the channel bit is moot
   assign waveUnderflow = modeCfg.waveChannelSelect ? t1Underflow : t0Underflow;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wave_reg <= 1'b0;
      end else if (wide ? t1Underflow : waveUnderflow) begin
         wave_reg <= !wave_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         serial_reg <= 1'b0;
      end else if (t1Underflow) begin
         serial_reg <= !serial_reg;
      end
   end

   assign serialClock = serial_reg;

   // gated without resync, so a switch mid-phase can clip one half period
   assign squareWaveOut = modeCfg.waveOutputEnable ? wave_reg : 1'b1;

   // pin follows the port: only a data bit of 1 passes the wave through
   assign wavePinOut = wavePortPin && squareWaveOut;
   assign wavePinOe = !wavePortHizCtrl;

endmodule

// ### testbench/drt_timer_props.sv
// concurrent checks on the dual reload timer ports
// bound into drt_timer from the bench top file; one clock domain
`timescale 1ns/100ps
module drt_timer_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire drt_pkg::drt_mode_cfg_t modeCfg,
   input wire logic t0PresetBit,
   input wire logic [7:0] t0ReloadValue,
   input wire logic t0IrqMask,
   input wire logic t1IrqMask,
   input wire logic t0IrqClear,
   input wire logic lowReadStrobe,
   input wire logic wavePortPin,
   input wire logic t0IrqFlag,
   input wire logic t1IrqFlag,
   input wire logic t0IrqReq,
   input wire logic t1IrqReq,
   input wire logic t0Underflow,
   input wire logic t1Underflow,
   input wire drt_pkg::drt_count_read_t countReadBuffer,
   input wire logic squareWaveOut,
   input wire logic wavePinOut,
   input wire logic serialClock
);
   import drt_pkg::*;
   logic waveSel;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // wide mode drives the wave from the combined underflow
   assign waveSel = (modeCfg.waveChannelSelect | modeCfg.widthModeBit) ?
                    t1Underflow : t0Underflow;
   ////////////////////////////////////////
   chk_flag_set: assert property (t0Underflow |=> t0IrqFlag)
      else $error("flag not set");
   chk_irq_req: assert property (t0IrqReq == (t0IrqFlag & t0IrqMask)
      && t1IrqReq == (t1IrqFlag & t1IrqMask)) else $error("bad request");
   chk_flag_clear: assert property (t0IrqClear && !t0Underflow |=> !t0IrqFlag)
      else $error("flag not cleared");
   chk_preset_load: assert property (t0PresetBit
      |=> countReadBuffer.t0Count == $past(t0ReloadValue)) else $error("no preset");
   chk_uf_reload: assert property (t0Underflow && !t0PresetBit
      |=> countReadBuffer.t0Count == $past(t0ReloadValue)) else $error("no reload");
   chk_wave_toggle: assert property (modeCfg.waveOutputEnable && waveSel
      ##1 modeCfg.waveOutputEnable |-> squareWaveOut != $past(squareWaveOut))
      else $error("wave stuck");
   chk_pin_gate: assert property (wavePinOut == (wavePortPin & squareWaveOut)
      && (modeCfg.waveOutputEnable || squareWaveOut)) else $error("bad pin");
   chk_serial_toggle: assert property (t1Underflow |=> serialClock != $past(serialClock))
      else $error("serial clock stuck");
   chk_flag_wide: assert property (modeCfg.widthModeBit && t1Underflow |=> t1IrqFlag)
      else $error("wide flag not set");
   chk_held_high: assert property (lowReadStrobe
      |=> countReadBuffer.heldHigh == $past(countReadBuffer.t1Count)) else $error("no hold");
endmodule

// ### testbench/drt_event_source.sv
// event pin source and serial clock watcher outside the timer
// driven by the bench through its pulse task on the system clock
`timescale 1ns/100ps
module drt_event_source (
   input wire logic clk,
   input wire logic serialClock,
   output logic eventPin
);
   int serialRises = 0;
   initial eventPin = 1'b1;
   always @(posedge serialClock) serialRises++;
   // callers keep real levels above the rejector minimum
   task automatic pulse(input int lo, input int hi);
      @(posedge clk);
      eventPin <= 1'b0;
      repeat (lo) @(posedge clk);
      eventPin <= 1'b1;
      repeat (hi) @(posedge clk);
   endtask
endmodule

// ### testbench/drt_timer_tb.sv
// self-checking bench for drt_timer: clock setting table, then hand tests
// assumes drt_pkg, drt_timer, drt_event_source and drt_timer_props
`timescale 1ns/100ps
module drt_timer_tb;
   import drt_pkg::*;
   logic clk = 0, rst_n = 0, slowOsc = 0, fastOsc = 0, refClk = 0, t0Mask = 0;
   logic eventPin, serialClock, squareWaveOut, wavePinOut, wavePinOe;
   logic t0IrqFlag, t1IrqFlag, t0IrqReq, t1IrqReq, t0Uf, t1Uf;
   logic [4:0] pulses = 5'h00;
   logic [7:0] t0Rld = 8'h00, t1Rld = 8'h00;
   logic [15:0] c;
   drt_mode_cfg_t modeCfg = '0;
   drt_timer_cfg_t t0Cfg = '0, t1Cfg = '0;
   drt_count_read_t cnt;
   int nErrors = 0, testsRun = 0, phase = 0, slowN = 0, fastN = 0;
   // {source, divider, reload, source ticks per underflow}
   logic [22:0] rows [4] = '{{1'h0, DIV_BY_1, 8'h05, 12'h006},
      {1'h1, DIV_BY_4, 8'h03, 12'h010}, {1'h0, DIV_BY_32, 8'h02, 12'h060},
      {1'h1, DIV_BY_256, 8'h00, 12'h100}};
   ////////////////////////////////////////
   initial forever #20 clk = ~clk;
   // reference runs fast so the rejector test stays short
   always @(posedge clk) begin
      phase <= phase + 1;
      slowOsc <= phase % 10 < 5;
      fastOsc <= phase % 6 < 3;
      refClk <= phase % 20 < 10;
   end
   always @(posedge slowOsc) slowN++;
   always @(posedge fastOsc) fastN++;
   drt_timer i_drt_timer (.clk, .rst_n, .slowOscillator(slowOsc), .fastOscillator(fastOsc),
      .refClock2048(refClk), .eventInputPin(eventPin), .modeCfg, .t0Cfg, .t1Cfg,
      .t0PresetBit(pulses[0]), .t1PresetBit(pulses[1]), .t0ReloadValue(t0Rld),
      .t1ReloadValue(t1Rld), .t0IrqMask(t0Mask), .t1IrqMask(!t0Mask), .t0IrqClear(pulses[2]),
      .t1IrqClear(pulses[3]), .lowReadStrobe(pulses[4]), .wavePortPin(1'b1),
      .wavePortHizCtrl(1'b0), .t0IrqFlag, .t1IrqFlag, .t0IrqReq, .t1IrqReq,
      .t0Underflow(t0Uf), .t1Underflow(t1Uf), .countReadBuffer(cnt), .squareWaveOut,
      .wavePinOut, .wavePinOe, .serialClock);
   drt_event_source i_drt_event_source (.clk, .serialClock, .eventPin);
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nErrors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic fire(input logic [4:0] p);
      @(posedge clk);
      pulses <= p;
      @(posedge clk);
      pulses <= 5'h00;
   endtask
   task automatic waitUf(input logic hi);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while ((hi ? t1Uf : t0Uf) !== 1'b1 && k < 5000);
      if (k >= 5000) nErrors++;
   endtask
   task automatic period(input logic hi, input logic fast, input logic [11:0] ticks);
      int a;
      waitUf(hi);
      a = fast ? fastN : slowN;
      waitUf(hi);
      check(32'((fast ? fastN : slowN) - a), 32'(ticks));
   endtask
   task final_report;
      if (nErrors == 0 && testsRun > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check({cnt, t0IrqFlag, t1IrqFlag, squareWaveOut, serialClock, wavePinOe}, 32'h5);
      foreach (rows[i]) begin
         @(posedge clk);
         {t0Cfg.sourceSelect, t0Cfg.divider, t0Rld} <= rows[i][22:12];
         {t1Cfg.sourceSelect, t1Cfg.divider, t1Rld} <= rows[i][22:12];
         {t0Cfg.runBit, t1Cfg.runBit} <= 2'h0;
         modeCfg.waveChannelSelect <= i[0];
         modeCfg.waveOutputEnable <= 1'b1;
         t0Mask <= i[0];
         fire(5'h03);
         {t0Cfg.runBit, t1Cfg.runBit} <= 2'h3;
         period(1'b0, rows[i][22], rows[i][11:0]);
         period(1'b1, rows[i][22], rows[i][11:0]);
      end
      @(posedge clk);
      {t0Cfg.runBit, t1Cfg.runBit} <= 2'h0;
      fire(5'h0C);
      @(negedge clk);
      check({t0IrqFlag, t1IrqFlag}, 32'h0);
      @(posedge clk);
      t0Rld <= 8'h40;
      t0Cfg <= {1'b0, DIV_BY_1, 1'b0};
      fire(5'h01);
      t0Cfg.runBit <= 1'b1;
      repeat (100) @(posedge clk);
      t0Cfg.runBit <= 1'b0;
      repeat (10) @(negedge clk);
      c = cnt.t0Count;
      repeat (100) @(negedge clk);
      check(cnt.t0Count, c);
      @(posedge clk);
      t0Cfg.runBit <= 1'b1;
      repeat (100) @(negedge clk);
      check(cnt.t0Count < c, 32'h1);
      // timer settings left hostile: event mode must ignore them
      @(posedge clk);
      modeCfg.counterModeBit <= 1'b1;
      t0Cfg <= {1'b1, DIV_BY_256, 1'b1};
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         modeCfg.edgePolarityBit <= p[0];
         fire(5'h01);
         repeat (3) i_drt_event_source.pulse(8, 8);
         repeat (10) @(negedge clk);
         check(cnt.t0Count, 32'h3D);
      end
      @(posedge clk);
      modeCfg.filterSelectBit <= 1'b1;
      repeat (200) @(posedge clk);
      fire(5'h01);
      i_drt_event_source.pulse(4, 60);
      repeat (2) i_drt_event_source.pulse(60, 60);
      @(negedge clk);
      check(cnt.t0Count, 32'h3E);
      @(posedge clk);
      modeCfg <= 6'h21;
      t0Cfg <= {1'b1, DIV_BY_1, 1'b0};
      t0Rld <= 8'h02;
      t1Rld <= 8'h01;
      fire(5'h03);
      t0Cfg.runBit <= 1'b1;
      period(1'b1, 1'b1, 12'h103);
      @(negedge clk);
      check(t1IrqFlag, 32'h1);
      fire(5'h10);
      @(posedge clk);
      t0Cfg.runBit <= 1'b0;
      repeat (10) @(negedge clk);
      c = {cnt.t1Count, cnt.t0Count};
      repeat (100) @(negedge clk);
      check({cnt.t1Count, cnt.t0Count}, c);
      fire(5'h10);
      @(negedge clk);
      check(cnt.heldHigh, c[15:8]);
      check(i_drt_event_source.serialRises > 0, 32'h1);
      // mid-run reset: counts, flags, wave and serial clock all clear
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check({cnt, t0IrqFlag, t1IrqFlag, squareWaveOut, serialClock}, 32'h0);
      final_report();
   end
   initial begin
      repeat (60000) @(posedge clk);
      nErrors++;
      final_report();
   end
endmodule
bind drt_timer drt_timer_props i_drt_timer_props (.clk, .rst_n, .modeCfg, .t0PresetBit,
   .t0ReloadValue, .t0IrqMask, .t1IrqMask, .t0IrqClear, .lowReadStrobe, .wavePortPin,
   .t0IrqFlag, .t1IrqFlag, .t0IrqReq, .t1IrqReq, .t0Underflow, .t1Underflow,
   .countReadBuffer, .squareWaveOut, .wavePinOut, .serialClock);
